// ===== shared/fgr_pkg.sv
// Purpose: constants and types for the fine granularity refresh logic
// Assumes: 125 MHz core clock
// Notes:   refresh times held in ns, cycle counts derived
`default_nettype none
package fgr_pkg;

  // ************************************************************
  // granularity field codes (mode register bits 8:6)
  // ************************************************************
  typedef enum logic [2:0] {
    FGR_FIX1X = 3'h0,
    FGR_FIX2X = 3'h1,
    FGR_FIX4X = 3'h2,
    FGR_OTF2X = 3'h5,
    FGR_OTF4X = 3'h6
  } fgr_mode_e;

  typedef enum logic [1:0] {
    FGR_RATE1X = 2'h0,
    FGR_RATE2X = 2'h1,
    FGR_RATE4X = 2'h2
  } fgr_rate_e;

  localparam logic [2:0] FGR_MODE_RST = 3'h0;
  localparam int         FGR_FLD_LO   = 6;
  localparam int         FGR_FLD_HI   = 8;
  localparam int         FGR_TCR_BIT  = 3;
  localparam int         FGR_TEMP_BIT = 2;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int FGR_CLK_PS     = 8000;
  localparam int FGR_REFI_NS    = 7800;
  // tRFC per rate (1x,2x,4x) per density (2Gb,4Gb,8Gb), ns
  localparam int FGR_RFC1_NS [3] = '{160, 260, 350};
  localparam int FGR_RFC2_NS [3] = '{110, 160, 260};
  localparam int FGR_RFC4_NS [3] = '{90, 110, 160};

  // least time rounds up
  function automatic logic [7:0] fgr_cyc(input int ns);
    fgr_cyc = 8'((ns * 1000 + FGR_CLK_PS - 1) / FGR_CLK_PS);
  endfunction : fgr_cyc

  localparam logic [15:0] FGR_REFI_CYC = 16'(FGR_REFI_NS * 1000 / FGR_CLK_PS);

  // refresh command as seen on the command decode
  typedef struct packed {
    logic valid;
    logic bg0;
  } fgr_refcmd_s;

endpackage : fgr_pkg

`default_nettype wire

// ===== hdl/fgr_refresh.sv
// Purpose: device-side refresh granularity decode and bookkeeping
// Assumes: commands already decoded, one cycle strobes, sync inputs
// Notes:   flags mark controller slips; the device never refuses self-refresh entry
`timescale 1ns/1ns
`default_nettype none

module fgr_refresh
  import fgr_pkg::*;
(
  input  wire  logic        CLK_IN,
  input  wire  logic        RST_IN,
  input  wire  logic        MR3_WR_IN,
  input  wire  logic        MR4_WR_IN,
  input  wire  logic [13:0] MR_DATA_IN,
  input  wire  fgr_refcmd_s REF_IN,
  input  wire  logic        SRE_IN,
  input  wire  logic        SRX_IN,
  input  wire  logic        HOT_IN,
  input  wire  logic [1:0]  DENSITY_IN,
  output logic [2:0]        MODE_OUT,
  output logic [1:0]        RATE_OUT,
  output logic [15:0]       REFI_CYC_OUT,
  output logic [7:0]        RFC_CYC_OUT,
  output logic              BUSY_OUT,
  output logic              SR_ACTIVE_OUT,
  output logic [2:0]        EXTRA_OUT,
  output logic              TCR_EN_OUT,
  output logic              TCR_EXT_OUT,
  output logic              ERR_RSVD_OUT,
  output logic              ERR_TYPE_OUT,
  output logic              ERR_COUNT_OUT,
  output logic              ERR_TCR_OUT
);

  // ************************************************************
  // mode register state
  // ************************************************************
  logic [2:0] mode_ff;
  logic [1:0] rate_ff;
  logic       tcr_en_ff;
  logic       tcr_ext_ff;
  logic [1:0] frac_cnt_ff;
  logic [2:0] extra_ff;
  logic       sr_ff;
  logic [7:0] busy_cnt_ff;
  logic [7:0] rfc_cyc;
  logic       err_rsvd_ff;
  logic       err_type_ff;
  logic       err_count_ff;
  logic       err_tcr_ff;

  logic [2:0] wr_code;
  logic       code_ok;
  logic [1:0] code_rate;
  logic       otf;
  logic [1:0] ref_rate;
  logic       type_ok;
  logic       rate_chg;
  logic       frac_bad;
  logic [1:0] dens;

  assign wr_code = MR_DATA_IN[FGR_FLD_HI:FGR_FLD_LO];
  assign dens    = (DENSITY_IN > 2'h2) ? 2'h2 : DENSITY_IN;

  always_comb begin
    code_ok   = 1'b1;
    code_rate = FGR_RATE1X;
    unique case (wr_code)
      FGR_FIX1X: code_rate = FGR_RATE1X;
      FGR_FIX2X, FGR_OTF2X: code_rate = FGR_RATE2X;
      FGR_FIX4X, FGR_OTF4X: code_rate = FGR_RATE4X;
      default: code_ok = 1'b0;
    endcase
  end

  assign otf = mode_ff[2];
  assign ref_rate = (otf && !REF_IN.bg0) ? FGR_RATE1X :
                    (mode_ff == FGR_FIX1X) ? FGR_RATE1X :
                    (mode_ff == FGR_FIX2X || mode_ff == FGR_OTF2X) ? FGR_RATE2X : FGR_RATE4X;
  // on-the-fly refresh in fixed 1x mode is the wrong type
  assign type_ok  = otf || !REF_IN.bg0 || mode_ff != FGR_FIX1X;
  // same rate is not a change
  assign rate_chg = code_ok && code_rate != rate_ff;
  assign frac_bad = (rate_ff == FGR_RATE2X) ? frac_cnt_ff[0] :
                    (rate_ff == FGR_RATE4X) ? (frac_cnt_ff != 2'h0) : 1'b0;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      mode_ff <= FGR_MODE_RST;
      rate_ff <= FGR_RATE1X;
    end else if (MR3_WR_IN && code_ok) begin
      mode_ff <= wr_code;
      rate_ff <= code_rate;
    end else if (REF_IN.valid && !sr_ff && otf) begin
      rate_ff <= ref_rate;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tcr_en_ff  <= 1'b0;
      tcr_ext_ff <= 1'b0;
    end else if (MR4_WR_IN) begin
      tcr_en_ff  <= MR_DATA_IN[FGR_TCR_BIT];
      tcr_ext_ff <= MR_DATA_IN[FGR_TEMP_BIT];
    end
  end

  // ************************************************************
  // fractional refresh counter and self refresh
  // ************************************************************
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      frac_cnt_ff <= 2'h0;
    end else if (MR3_WR_IN || SRX_IN) begin
      frac_cnt_ff <= 2'h0;
    end else if (REF_IN.valid && !sr_ff) begin
      frac_cnt_ff <= (ref_rate == FGR_RATE1X) ? 2'h0 : frac_cnt_ff + 2'h1;
    end
  end

  // entry never refused
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      sr_ff <= 1'b0;
    end else if (SRE_IN) begin
      sr_ff <= 1'b1;
    end else if (SRX_IN) begin
      sr_ff <= 1'b0;
    end
  end

  // extra refreshes owed after exit; these also advance the fractional counter
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      extra_ff <= 3'h0;
    end else if (SRE_IN && !sr_ff) begin
      if (rate_ff == FGR_RATE2X && frac_cnt_ff[0]) begin
        extra_ff <= 3'h2;
      end else if (rate_ff == FGR_RATE4X && frac_cnt_ff != 2'h0) begin
        extra_ff <= 3'h4;
      end else begin
        extra_ff <= 3'h0;
      end
    end else if (REF_IN.valid && !sr_ff && extra_ff != 3'h0) begin
      extra_ff <= (ref_rate == FGR_RATE1X) ? 3'h0 : extra_ff - 3'h1;
    end
  end

  // ************************************************************
  // refresh cycle time
  // ************************************************************
  always_comb begin
    unique case (ref_rate)
      FGR_RATE2X: rfc_cyc = fgr_cyc(FGR_RFC2_NS[dens]);
      FGR_RATE4X: rfc_cyc = fgr_cyc(FGR_RFC4_NS[dens]);
      default:    rfc_cyc = fgr_cyc(FGR_RFC1_NS[dens]);
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      busy_cnt_ff <= 8'h00;
    end else if (REF_IN.valid && !sr_ff) begin
      busy_cnt_ff <= rfc_cyc;
    end else if (busy_cnt_ff != 8'h00) begin
      busy_cnt_ff <= busy_cnt_ff - 8'h01;
    end
  end

  // ************************************************************
  // sticky protocol flags, cleared only by reset
  // ************************************************************
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      err_rsvd_ff  <= 1'b0;
      err_type_ff  <= 1'b0;
      err_count_ff <= 1'b0;
      err_tcr_ff   <= 1'b0;
    end else begin
      if (MR3_WR_IN && !code_ok) err_rsvd_ff <= 1'b1;
      if (REF_IN.valid && !sr_ff && !type_ok) err_type_ff <= 1'b1;
      if (MR3_WR_IN && rate_chg && frac_bad) err_count_ff <= 1'b1;
      if (REF_IN.valid && !sr_ff && otf && !REF_IN.bg0 && frac_bad && extra_ff == 3'h0)
        err_count_ff <= 1'b1;
      if (tcr_en_ff && mode_ff != FGR_FIX1X) err_tcr_ff <= 1'b1;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb begin
    unique case (rate_ff)
      FGR_RATE2X: REFI_CYC_OUT = FGR_REFI_CYC >> 1;
      FGR_RATE4X: REFI_CYC_OUT = FGR_REFI_CYC >> 2;
      default:    REFI_CYC_OUT = FGR_REFI_CYC;
    endcase
    if (HOT_IN) REFI_CYC_OUT = REFI_CYC_OUT >> 1;
  end

  assign MODE_OUT      = mode_ff;
  assign RATE_OUT      = rate_ff;
  assign RFC_CYC_OUT   = busy_cnt_ff;
  assign BUSY_OUT      = busy_cnt_ff != 8'h00;
  assign SR_ACTIVE_OUT = sr_ff;
  assign EXTRA_OUT     = extra_ff;
  assign TCR_EN_OUT    = tcr_en_ff;
  assign TCR_EXT_OUT   = tcr_ext_ff;
  assign ERR_RSVD_OUT  = err_rsvd_ff;
  assign ERR_TYPE_OUT  = err_type_ff;
  assign ERR_COUNT_OUT = err_count_ff;
  assign ERR_TCR_OUT   = err_tcr_ff;

  // ************************************************************
  // checks
  // ************************************************************
  a_reset_mode: assert property (@(posedge CLK_IN) RST_IN |=> mode_ff == FGR_FIX1X)
    else $error("mode not fixed 1x after reset");
  a_otf_rate: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (REF_IN.valid && !sr_ff && otf && !MR3_WR_IN && !REF_IN.bg0) |=> rate_ff == FGR_RATE1X)
    else $error("bg0 low did not give 1x");
  a_busy_len: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (REF_IN.valid && !sr_ff) |=> busy_cnt_ff == $past(rfc_cyc))
    else $error("busy count wrong");
  a_busy_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (REF_IN.valid && !sr_ff && rfc_cyc > 8'h02) |=> BUSY_OUT [*2])
    else $error("busy dropped early");
  a_rsvd_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (MR3_WR_IN && !code_ok) |=> ERR_RSVD_OUT && $stable(mode_ff))
    else $error("reserved code accepted");
  a_frac_clr: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (MR3_WR_IN || SRX_IN) |=> frac_cnt_ff == 2'h0)
    else $error("counter not cleared");
  a_sr_accept: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    SRE_IN |=> SR_ACTIVE_OUT)
    else $error("self refresh refused");
  a_extra_4x: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (SRE_IN && !sr_ff && rate_ff == FGR_RATE4X && frac_cnt_ff != 2'h0) |=> extra_ff == 3'h4)
    else $error("extra 4x not requested");
  a_hot_refi: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (HOT_IN && rate_ff == FGR_RATE1X) |-> REFI_CYC_OUT == (FGR_REFI_CYC >> 1))
    else $error("hot interval not halved");
  a_tcr_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (tcr_en_ff && mode_ff != FGR_FIX1X) |=> ERR_TCR_OUT)
    else $error("temperature refresh misuse not flagged");

endmodule : fgr_refresh

`default_nettype wire

// ===== sim/fgr_ctrl_model.sv
// Purpose: controller side driver of mode writes, refreshes and self-refresh
// Assumes: commands launched at the falling clock edge
// Notes:   one-cycle pulses; address lines toggled once released
`timescale 1ns/1ns
`default_nettype none
module fgr_ctrl_model
  import fgr_pkg::*;
(
  input  wire logic   clk_in,
  output logic        mr3_wr_out,
  output logic        mr4_wr_out,
  output logic [13:0] mr_data_out,
  output fgr_refcmd_s ref_out,
  output logic        sre_out,
  output logic        srx_out
);
  // ************************************************************
  // command tasks
  // ************************************************************
  task automatic release_all();
    mr3_wr_out = 1'b0;
    mr4_wr_out = 1'b0;
    ref_out = '0;
    sre_out = 1'b0;
    srx_out = 1'b0;
    // stale address must not look like a held value
    mr_data_out = ~mr_data_out;
  endtask : release_all

  initial begin
    mr_data_out = 14'h0000;
    release_all();
  end

  // mode select always precedes on-the-fly refreshes
  task automatic mr3(input logic [2:0] code);
    @(negedge clk_in);
    mr_data_out = {5'h00, code, 6'h00};
    mr3_wr_out = 1'b1;
    @(negedge clk_in);
    release_all();
  endtask : mr3

  // temperature refresh enable and range bits
  task automatic mr4(input logic tcr, input logic ext);
    @(negedge clk_in);
    mr_data_out = {10'h000, tcr, ext, 2'h0};
    mr4_wr_out = 1'b1;
    @(negedge clk_in);
    release_all();
  endtask : mr4

  task automatic refresh(input logic bg0);
    @(negedge clk_in);
    ref_out = '{valid: 1'b1, bg0: bg0};
    @(negedge clk_in);
    release_all();
  endtask : refresh

  task automatic self_ref(input logic entry);
    @(negedge clk_in);
    sre_out = entry;
    srx_out = !entry;
    @(negedge clk_in);
    release_all();
  endtask : self_ref
endmodule : fgr_ctrl_model
`default_nettype wire

// ===== sim/test_fine_granularity_refresh.sv
// Purpose: self-checking bench for the refresh granularity logic
// Assumes: outputs settle one edge after a command pulse
// Notes:   sticky flags are checked low before the step that sets them
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, got); end end
module test_fine_granularity_refresh
  import fgr_pkg::*;
;
  logic clk, rst, hot, m3, m4, sre, srx, busy, sra, tcr, tce, er, et, ec, ex;
  logic [1:0]  dens, rate;
  logic [2:0]  mode, extra;
  logic [7:0]  rfc;
  logic [13:0] mdat;
  logic [15:0] refi;
  fgr_refcmd_s rcmd;
  int n_mismatch = 0;
  int checked = 0;

  fgr_ctrl_model ctl (.clk_in(clk), .mr3_wr_out(m3), .mr4_wr_out(m4), .mr_data_out(mdat),
    .ref_out(rcmd), .sre_out(sre), .srx_out(srx));
  fgr_refresh uut (.CLK_IN(clk), .RST_IN(rst), .MR3_WR_IN(m3), .MR4_WR_IN(m4),
    .MR_DATA_IN(mdat), .REF_IN(rcmd), .SRE_IN(sre), .SRX_IN(srx), .HOT_IN(hot),
    .DENSITY_IN(dens), .MODE_OUT(mode), .RATE_OUT(rate), .REFI_CYC_OUT(refi),
    .RFC_CYC_OUT(rfc), .BUSY_OUT(busy), .SR_ACTIVE_OUT(sra), .EXTRA_OUT(extra),
    .TCR_EN_OUT(tce), .TCR_EXT_OUT(tcr), .ERR_RSVD_OUT(er), .ERR_TYPE_OUT(et),
    .ERR_COUNT_OUT(ec), .ERR_TCR_OUT(ex));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // bounded wait for the refresh cycle time to run out
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (busy !== 1'b0) begin
      n_mismatch++;
      $display("CHECK FAILED BUSY_OUT exp 0 seen 1");
      tally_and_finish();
    end
  endtask : wait_idle

  // short reset in mid-run; sticky flags must clear
  task automatic pulse_reset();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
  endtask : pulse_reset

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    hot = 1'b0;
    dens = 2'h0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    `CHK("MODE_OUT", FGR_MODE_RST, mode)
    `CHK("REFI_CYC_OUT", 16'h03CF, refi)
    `CHK("flags", 4'h0, {er, et, ec, ex})
    hot = 1'b1;
    @(negedge clk);
    `CHK("REFI_CYC_OUT hot", 16'h01E7, refi)
    hot = 1'b0;
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      ctl.mr3(i[1] ? {1'b1, i[0], !i[0]} : {1'b0, i[0], !i[0]});
      `CHK("MODE_OUT", i[1] ? {1'b1, i[0], !i[0]} : {1'b0, i[0], !i[0]}, mode)
    end
    `CHK("ERR_RSVD_OUT", 1'b0, er)
    ctl.mr3(3'h3);
    `CHK("MODE_OUT kept", 3'h6, mode)
    `CHK("ERR_RSVD_OUT", 1'b1, er)
    $display("test modes done");
    ctl.mr3(FGR_FIX2X);
    ctl.refresh(1'b1);
    `CHK("RFC_CYC_OUT", 8'h0E, rfc)
    `CHK("RATE_OUT", 2'h1, rate)
    `CHK("REFI_CYC_OUT", 16'h01E7, refi)
    repeat (13) @(negedge clk);
    `CHK("BUSY_OUT", 1'b1, busy)
    @(negedge clk);
    `CHK("BUSY_OUT", 1'b0, busy)
    $display("test cycle time done");
    ctl.refresh(1'b0);
    wait_idle();
    ctl.refresh(1'b0);
    wait_idle();
    `CHK("ERR_TYPE_COUNT", 2'h0, {et, ec})
    ctl.self_ref(1'b1);
    `CHK("SR_ACTIVE_OUT", 1'b1, sra)
    ctl.refresh(1'b0);
    `CHK("RFC_CYC_OUT in self-refresh", 8'h00, rfc)
    ctl.self_ref(1'b0);
    `CHK("EXTRA_OUT", 3'h2, extra)
    for (int i = 0; i < 2; i++) begin
      ctl.refresh(1'b0);
      wait_idle();
    end
    `CHK("EXTRA_OUT paid", 3'h0, extra)
    $display("test self-refresh done");
    dens = 2'h2;
    ctl.mr3(FGR_OTF4X);
    ctl.refresh(1'b1);
    `CHK("RFC_CYC_OUT quad", 8'h14, rfc)
    `CHK("REFI_CYC_OUT quad", 16'h00F3, refi)
    hot = 1'b1;
    @(negedge clk);
    `CHK("REFI_CYC_OUT quad hot", 16'h0079, refi)
    hot = 1'b0;
    wait_idle();
    `CHK("ERR_COUNT_OUT", 1'b0, ec)
    ctl.refresh(1'b0);
    `CHK("RATE_OUT normal", 2'h0, rate)
    `CHK("RFC_CYC_OUT normal", 8'h2C, rfc)
    `CHK("ERR_COUNT_OUT", 1'b1, ec)
    wait_idle();
    ctl.mr3(FGR_FIX1X);
    ctl.refresh(1'b1);
    `CHK("ERR_TYPE_OUT", 1'b1, et)
    wait_idle();
    ctl.mr4(1'b1, 1'b1);
    `CHK("TCR_EN_EXT", 2'h3, {tce, tcr})
    `CHK("ERR_TCR_OUT", 1'b0, ex)
    ctl.mr3(FGR_FIX2X);
    // flag follows the new mode one edge later
    @(negedge clk);
    `CHK("ERR_TCR_OUT", 1'b1, ex)
    $display("test on-the-fly and errors done");
    pulse_reset();
    `CHK("flags cleared", 4'h0, {er, et, ec, ex})
    `CHK("MODE_OUT reset", 3'h0, mode)
    `CHK("TCR_EN_OUT reset", 1'b0, tce)
    dens = 2'h3;
    ctl.mr3(FGR_OTF2X);
    for (int i = 0; i < 2; i++) begin
      ctl.refresh(1'b1);
      `CHK("RFC_CYC_OUT 2x dens 3", 8'h21, rfc)
      wait_idle();
    end
    ctl.refresh(1'b0);
    `CHK("ERR_COUNT_OUT even", 1'b0, ec)
    wait_idle();
    ctl.refresh(1'b1);
    wait_idle();
    ctl.refresh(1'b0);
    `CHK("ERR_COUNT_OUT odd", 1'b1, ec)
    wait_idle();
    $display("test pairing done");
    pulse_reset();
    dens = 2'h1;
    ctl.mr3(FGR_FIX4X);
    for (int i = 0; i < 4; i++) begin
      ctl.refresh(1'b0);
      `CHK("RFC_CYC_OUT 4x dens 1", 8'h0E, rfc)
      wait_idle();
    end
    ctl.mr3(FGR_FIX1X);
    `CHK("ERR_COUNT_OUT four", 1'b0, ec)
    ctl.mr3(FGR_FIX2X);
    ctl.refresh(1'b1);
    wait_idle();
    ctl.mr3(FGR_OTF2X);
    `CHK("ERR_COUNT_OUT same rate", 1'b0, ec)
    ctl.refresh(1'b1);
    wait_idle();
    ctl.mr3(FGR_FIX4X);
    `CHK("ERR_COUNT_OUT odd 2x", 1'b1, ec)
    ctl.refresh(1'b0);
    wait_idle();
    ctl.self_ref(1'b1);
    ctl.self_ref(1'b0);
    `CHK("EXTRA_OUT quad", 3'h4, extra)
    for (int i = 0; i < 4; i++) begin
      ctl.refresh(1'b0);
      wait_idle();
    end
    `CHK("EXTRA_OUT quad paid", 3'h0, extra)
    $display("test rate change done");
    tally_and_finish();
  end
endmodule : test_fine_granularity_refresh
`default_nettype wire
